//--- core/sweep_handler_status_outputs.sv
// handler control and result outputs for list sweep comparison
`timescale 1ns/100ps
module sweep_handler_status_outputs
   import handler_out_pkg::*;
#(
   parameter int POINTS = NUM_POINTS
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // mode
   input wire logic sequential_sweep,
   // sweep events
   input wire logic meas_start,
   input wire logic point_analog_done,
   input wire logic point_compare_done,
   input wire logic point_fail,
   input wire logic [POINT_IDX_W-1:0] point_index,
   input wire logic last_point,
   // handler pins
   output logic analog_done_n,
   output logic measure_end_n,
   output logic [POINTS-1:0] point_fail_n,
   output logic summary_fail_n
);
   logic [POINTS-1:0] fail_reg;
   logic [POINTS-1:0] fail_next;
   logic [POINTS-1:0] pin_reg;
   logic sum_reg;
   logic seq_idx_set;
   logic step_idx_set;
   logic idx_set;
   logic end_set;
   logic step_begin;
   logic end_clear;
   logic idx_clear;
   logic [POINTS-1:0] point_bit;
   logic [POINTS-1:0] fail_hit;
   logic [POINTS-1:0] fail_base;

   assign point_bit = POINTS'(1) << point_index;

   assign seq_idx_set = sequential_sweep && point_analog_done && last_point; // R1
   assign step_idx_set = !sequential_sweep && point_analog_done; // R2
   assign idx_set = seq_idx_set || step_idx_set;
   // results latch to pins together with measurement-end
   assign end_set = point_compare_done
      && (!sequential_sweep || last_point); // R4 R5
   // stepwise: the next point's analog result drops measurement-end
   assign step_begin = !sequential_sweep && point_analog_done;
   assign idx_clear = meas_start; // R8
   assign end_clear = meas_start || (step_begin && !end_set); // R8

   assign fail_hit = (point_compare_done && point_fail)
      ? point_bit : '0; // R6
   // a fail seen in the start cycle is kept: set wins over clear
   assign fail_base = meas_start ? '0 : fail_reg;
   assign fail_next = fail_base | fail_hit; // R6

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         fail_reg <= '0;
      else
         fail_reg <= fail_next;
   end

   // pins update only when measurement-end asserts
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pin_reg <= '0;
         sum_reg <= 1'b0;
      end
      else if (end_set)
      begin
         pin_reg <= fail_next; // R3 R6
         sum_reg <= |fail_next; // R7
      end
   end

   assign point_fail_n = ~pin_reg; // R8
   assign summary_fail_n = ~sum_reg; // R8

   active_low_flag u_index
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .set(idx_set),
      .clear(idx_clear),
      .flag_n(analog_done_n)
   );

   active_low_flag u_end
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .set(end_set),
      .clear(end_clear),
      .flag_n(measure_end_n)
   );

   // reset and start
   reset_idle_a: assert property (@(posedge clk_sys) // R8
      rst
      |=> analog_done_n && measure_end_n
      && (&point_fail_n) && summary_fail_n)
      else $error("outputs not idle after reset");

   start_clears_a: assert property (@(posedge clk_sys) // R8
      disable iff (rst)
      meas_start && !idx_set && !end_set
      |=> analog_done_n && measure_end_n)
      else $error("done outputs not dropped at start");

   start_index_clear_a: assert property (@(posedge clk_sys) // R8
      disable iff (rst)
      meas_start && !point_analog_done
      |=> analog_done_n)
      else $error("analog-done kept over a start");

   start_end_clear_a: assert property (@(posedge clk_sys) // R8
      disable iff (rst)
      meas_start && !point_compare_done
      |=> measure_end_n)
      else $error("measurement-end kept over a start");

   // analog-done
   seq_index_last_a: assert property (@(posedge clk_sys) // R1
      disable iff (rst)
      sequential_sweep && point_analog_done && !last_point
      && !$past(seq_idx_set) && analog_done_n
      |=> analog_done_n)
      else $error("analog-done before last point");

   seq_index_set_a: assert property (@(posedge clk_sys) // R1
      disable iff (rst)
      sequential_sweep && point_analog_done && last_point
      |=> !analog_done_n)
      else $error("analog-done missing at last point");

   step_index_set_a: assert property (@(posedge clk_sys) // R2
      disable iff (rst)
      !sequential_sweep && point_analog_done
      |=> !analog_done_n)
      else $error("analog-done missing in stepwise point");

   index_only_a: assert property (@(posedge clk_sys) // R2
      disable iff (rst)
      analog_done_n && !point_analog_done
      |=> analog_done_n)
      else $error("analog-done without analog result");

   index_fall_a: assert property (@(posedge clk_sys) // R1
      disable iff (rst)
      $fell(analog_done_n)
      |-> $past(point_analog_done)
      && ($past(last_point) || !$past(sequential_sweep)))
      else $error("analog-done fell without cause");

   index_holds_a: assert property (@(posedge clk_sys) // R8
      disable iff (rst)
      !analog_done_n && !meas_start
      |=> !analog_done_n)
      else $error("analog-done released before a start");

   // measurement-end
   seq_end_a: assert property (@(posedge clk_sys) // R4
      disable iff (rst)
      sequential_sweep && point_compare_done && last_point
      |=> !measure_end_n)
      else $error("measurement-end missing at end of sequence");

   seq_end_only_a: assert property (@(posedge clk_sys) // R4
      disable iff (rst)
      sequential_sweep && measure_end_n
      && !(point_compare_done && last_point)
      |=> measure_end_n)
      else $error("measurement-end before the sequence ended");

   step_end_a: assert property (@(posedge clk_sys) // R5
      disable iff (rst)
      !sequential_sweep && point_compare_done
      |=> !measure_end_n)
      else $error("measurement-end missing in stepwise point");

   end_fall_a: assert property (@(posedge clk_sys) // R4
      disable iff (rst)
      $fell(measure_end_n)
      |-> $past(point_compare_done)
      && ($past(last_point) || !$past(sequential_sweep)))
      else $error("measurement-end fell without cause");

   step_end_drop_a: assert property (@(posedge clk_sys) // R8
      disable iff (rst)
      !sequential_sweep && point_analog_done && !point_compare_done
      |=> measure_end_n)
      else $error("measurement-end kept over a new point");

   end_holds_a: assert property (@(posedge clk_sys) // R8
      disable iff (rst)
      !measure_end_n && !meas_start
      && !(point_analog_done && !sequential_sweep)
      |=> !measure_end_n)
      else $error("measurement-end released early");

   // results
   results_with_end_a: assert property (@(posedge clk_sys) // R3
      disable iff (rst)
      $changed(point_fail_n)
      |-> $fell(measure_end_n))
      else $error("results changed without measurement-end");

   summary_with_end_a: assert property (@(posedge clk_sys) // R3
      disable iff (rst)
      $changed(summary_fail_n)
      |-> $fell(measure_end_n))
      else $error("summary changed without measurement-end");

   pins_hold_a: assert property (@(posedge clk_sys) // R3
      disable iff (rst)
      !(point_compare_done && (!sequential_sweep || last_point))
      |=> $stable(point_fail_n) && $stable(summary_fail_n))
      else $error("results moved between measurement-ends");

   point_fail_pin_a: assert property (@(posedge clk_sys) // R6
      disable iff (rst)
      point_compare_done && point_fail
      && (!sequential_sweep || last_point)
      && point_index < POINT_IDX_W'(POINTS)
      |=> !point_fail_n[$past(point_index)])
      else $error("failed point not shown");

   index_range_a: assert property (@(posedge clk_sys) // R6
      disable iff (rst)
      !sequential_sweep && !meas_start && point_compare_done
      && point_index >= POINT_IDX_W'(POINTS)
      |=> (~point_fail_n & $past(point_fail_n)) == '0)
      else $error("out-of-range point shown as failed");

   summary_fail_a: assert property (@(posedge clk_sys) // R7
      disable iff (rst)
      summary_fail_n == &point_fail_n)
      else $error("summary fail disagrees with points");

   summary_set_a: assert property (@(posedge clk_sys) // R7
      disable iff (rst)
      point_compare_done && point_fail
      && (!sequential_sweep || last_point)
      && point_index < POINT_IDX_W'(POINTS)
      |=> !summary_fail_n)
      else $error("summary fail missing after a failed point");
endmodule : sweep_handler_status_outputs

//--- core/handler_out_pkg.sv
// constants for the handler status output block
// Behaviour
// R1: in sequential mode analog-done asserts once the last point's analog measurement completes.
// R2: in stepwise mode analog-done asserts after every point's analog measurement completes.
// R3: result outputs are only valid from measurement-end assertion, and the handler waits for it.
// R4: in sequential mode measurement-end asserts after the whole test ends with all results final.
// R5: in stepwise mode measurement-end asserts after each point's measurement and comparison end.
// R6: ten per-point fail outputs each assert when that point lies outside its limits.
// R7: the summary fail output asserts when any point of the list failed.
// R8: all outputs are active low, idle after reset, and the done outputs drop at each new start; here a set in the start cycle wins over the drop.
package handler_out_pkg;
   localparam int NUM_POINTS = 10;
   localparam int POINT_IDX_W = 4;
   localparam logic OUT_IDLE = 1'b1;
   localparam logic OUT_ACTIVE = 1'b0;
   localparam logic [NUM_POINTS-1:0] FAIL_IDLE = 10'h3FF;
endpackage : handler_out_pkg

//--- core/active_low_flag.sv
// one active-low handler status flag with set and clear
`timescale 1ns/100ps
module active_low_flag
   import handler_out_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // control
   input wire logic set,
   input wire logic clear,
   // pin
   output logic flag_n
);
   logic flag_reg;
   logic flag_next;

   // set wins over clear
   assign flag_next = set ? OUT_ACTIVE : (clear ? OUT_IDLE : flag_reg);

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         flag_reg <= OUT_IDLE;
      else
         flag_reg <= flag_next;
   end

   assign flag_n = flag_reg;
endmodule : active_low_flag

//--- tb/handler_model.sv
// handler model: samples results only once measurement-end asserts
`timescale 1ns/100ps
module handler_model
   import handler_out_pkg::*;
(
   // device pins
   input wire logic clk_sys,
   input wire logic measure_end_n,
   input wire logic [NUM_POINTS-1:0] point_fail_n,
   input wire logic summary_fail_n,
   // sampled results
   output logic [NUM_POINTS-1:0] seen_fail_n = FAIL_IDLE,
   output logic seen_sum_n = OUT_IDLE
);
   logic end_prev = OUT_IDLE;
   always @(posedge clk_sys)
   begin
      end_prev <= measure_end_n;
      if (end_prev && !measure_end_n)
      begin
         seen_fail_n <= point_fail_n;
         seen_sum_n <= summary_fail_n;
      end
   end
endmodule : handler_model

//--- tb/tb_sweep_handler_status_outputs.sv
// testbench for the handler status outputs
`timescale 1ns/100ps
module tb_sweep_handler_status_outputs;
   import handler_out_pkg::*;
   logic clk_sys = 0, rst = 1, sq = 1, st = 0, ad = 0, cd = 0, pf = 0, lp = 0;
   logic [POINT_IDX_W-1:0] idx = '0;
   logic adn, men, sfn, ssn;
   logic [NUM_POINTS-1:0] pfn, sfail;
   int n_mismatch = 0, compares = 0, cyc = 0;
   always #20 clk_sys = ~clk_sys;
   sweep_handler_status_outputs u_dut(.clk_sys(clk_sys), .rst(rst),
      .sequential_sweep(sq), .meas_start(st), .point_analog_done(ad),
      .point_compare_done(cd), .point_fail(pf), .point_index(idx),
      .last_point(lp), .analog_done_n(adn), .measure_end_n(men),
      .point_fail_n(pfn), .summary_fail_n(sfn));
   handler_model u_handler(.clk_sys(clk_sys), .measure_end_n(men),
      .point_fail_n(pfn), .summary_fail_n(sfn), .seen_fail_n(sfail),
      .seen_sum_n(ssn));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task ev(input logic a, c, f, input logic [3:0] i, input logic l);
      @(posedge clk_sys);
      #1 ad = a;
      cd = c;
      pf = f;
      idx = i;
      lp = l;
      @(posedge clk_sys);
      #1 ad = 0;
      cd = 0;
      pf = 0;
      lp = 0;
   endtask : ev
   task go(input logic m);
      sq = m;
      st = 1;
      @(posedge clk_sys);
      #1 st = 0;
      chk({adn, men}, 16'h0003);
   endtask : go
   task seq_run;
      go(1'b1);
      ev(1, 0, 0, 4'h0, 0);
      chk(adn, 16'h0001);
      ev(0, 1, 1, 4'h0, 0);
      chk({men, pfn}, 16'h07FF);
      ev(1, 0, 0, 4'h1, 1);
      chk(adn, 16'h0000);
      ev(0, 1, 0, 4'h1, 1);
      chk({men, sfn, pfn}, 16'h03FE);
      @(posedge clk_sys);
      #1 chk({ssn, sfail}, 16'h03FE);
   endtask : seq_run
   task step_run;
      go(1'b0);
      ev(1, 0, 0, 4'h4, 0);
      chk(adn, 16'h0000);
      ev(0, 1, 0, 4'h4, 0);
      chk({men, sfn, pfn}, 16'h07FF);
      ev(1, 0, 0, 4'h9, 1);
      chk(men, 16'h0001);
      ev(0, 1, 1, 4'h9, 1);
      chk({men, sfn, pfn}, 16'h01FF);
   endtask : step_run
   task reset_run;
      @(posedge clk_sys);
      #1 rst = 1;
      repeat (2) @(posedge clk_sys);
      #1 rst = 0;
      chk({adn, men, sfn, pfn}, 16'h1FFF);
   endtask : reset_run
   task edge_run;
      sq = 0;
      st = 1;
      ad = 1;
      idx = 4'hC;
      @(posedge clk_sys);
      #1 st = 0;
      ad = 0;
      chk({adn, men}, 16'h0001);
      ev(0, 1, 1, 4'hC, 1);
      chk({men, sfn, pfn}, 16'h07FF);
   endtask : edge_run
   task final_report;
      $display("n_mismatch=%0d compares=%0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc > 2000)
      begin
         n_mismatch++;
         final_report;
      end
   end
   initial
   begin
      repeat (8) @(posedge clk_sys);
      #1 rst = 0;
      chk({adn, men, sfn, pfn}, 16'h1FFF);
      seq_run;
      step_run;
      reset_run;
      edge_run;
      repeat (2) @(posedge clk_sys);
      final_report;
   end
endmodule : tb_sweep_handler_status_outputs
